// >>> ffa_defs.svh
// constants for the flash fetch accelerator: widths, field positions, resets, timing
// assumes a single 40 mhz ref_clk domain and a byte-addressed flash of two banks
// How it works
// - two flash banks, each reads independently and in parallel.
// - each bank owns one prefetch buffer and one branch trail buffer.
// - instruction miss in both buffers, no prefetch pending: load line into trail buffer.
// - completed speculative prefetch stores one line into bank's prefetch buffer.
// - line holds four words or eight halfwords; requested one is selected.
// - after a line's last word, that bank fetches its next line.
// - in full mode, branch target already buffered is supplied without flash read or stall.
// - branch target not buffered costs one flash access to refill trail buffer.
// - data reads use one shared line buffer, never prefetched.
// - data miss fetches a full four-word line into the data buffer.
// - each instruction buffer keeps a 12-bit compare address for hits.
// - data buffer is 128-bit data plus 13-bit address latch.
// - trail buffer holds latest miss; prefetch buffer holds speculative lines.
// - per-bank flash address latch; bank 0 latch has the incrementer.
// - programming is outside; sectors span both banks.
// - mode 00 off, 01 partial, 10 full, 11 reserved; off after reset.
// - any mode change invalidates every holding latch.
// - program or erase start invalidates all latches; refetch afterwards.
// - flash access lasts one to seven clocks, programmable.
`ifndef FFA_DEFS_SVH
`define FFA_DEFS_SVH
`define FFA_ADDR_W      15
`define FFA_LINE_W      128
`define FFA_CMP_W       12
`define FFA_DCMP_W      13
`define FFA_WORD_LSB    2
`define FFA_BANK_BIT    4
`define FFA_LINE_LSB    5
`define FFA_MODE_RST    2'h0
`define FFA_TIM_RST     3'h7
`define FFA_TIM_MIN     3'h1
`endif

// >>> ffa_pkg.sv
// types for the flash fetch accelerator
// assumes ffa_defs.svh is on the include path
`include "ffa_defs.svh"
package ffa_pkg;
    typedef enum logic [1:0] {
        FFA_MODE_OFF  = 2'h0,
        FFA_MODE_PART = 2'h1,
        FFA_MODE_FULL = 2'h2,
        FFA_MODE_RSVD = 2'h3
    } ffa_mode_type;
    typedef enum {
        FFA_IDLE,
        FFA_WAIT
    } ffa_state_type;
endpackage : ffa_pkg

// >>> ffa_bank.sv
// one flash bank read port with programmable access time
// assumes the flash array answers rd_line combinationally from bank_addr
`timescale 1ns/1ps
`include "ffa_defs.svh"
module ffa_bank
    import ffa_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   start,
    input  wire logic [`FFA_CMP_W-1:0]  line_addr,
    input  wire logic [2:0]             access_clks,
    input  wire logic [`FFA_LINE_W-1:0] rd_line,
    output logic      [`FFA_CMP_W-1:0]  bank_addr,
    output logic                        busy,
    output logic                        done,
    output logic      [`FFA_LINE_W-1:0] line_out
);
    logic [`FFA_CMP_W-1:0]  addr_q, addr_d;
    logic [2:0]             cnt_q, cnt_d;
    logic                   busy_q, busy_d;
    logic                   done_q, done_d;
    logic [`FFA_LINE_W-1:0] line_q, line_d;

    // address latch and access countdown, one per bank so both run in parallel
    always_comb begin
        addr_d = addr_q;
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        line_d = line_q;
        if (start && !busy_q) begin
            addr_d = line_addr;
            cnt_d  = (access_clks < `FFA_TIM_MIN) ? `FFA_TIM_MIN : access_clks;
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (cnt_q == `FFA_TIM_MIN) begin
                busy_d = 1'b0;
                done_d = 1'b1;
                line_d = rd_line;
            end else begin
                cnt_d = cnt_q - 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr_q <= '0;
            cnt_q  <= 3'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            line_q <= '0;
        end else begin
            addr_q <= addr_d;
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
            line_q <= line_d;
        end
    end

    assign bank_addr = addr_q;
    assign busy      = busy_q;
    assign done      = done_q;
    assign line_out  = line_q;
endmodule : ffa_bank

// >>> ffa_accel.sv
// flash fetch accelerator top: per-bank prefetch and trail buffers, shared data buffer
// assumes core holds req, addr, is_data, seq and half steady while stall is high
`timescale 1ns/1ps
`include "ffa_defs.svh"
module ffa_accel
    import ffa_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire logic [1:0]              accel_mode_control,
    input  wire logic [2:0]              flash_access_timing,
    input  wire logic                    prog_start,
    input  wire logic                    req,
    input  wire logic                    is_data,
    input  wire logic                    seq,
    input  wire logic                    half,
    input  wire logic [`FFA_ADDR_W-1:0]  addr,
    input  wire logic [`FFA_LINE_W-1:0]  bank0_rd_line,
    input  wire logic [`FFA_LINE_W-1:0]  bank1_rd_line,
    output logic      [`FFA_CMP_W-1:0]   bank0_addr,
    output logic      [`FFA_CMP_W-1:0]   bank1_addr,
    output logic                         stall,
    output logic                         rdata_valid,
    output logic      [31:0]             rdata
);
    ////////////////////////////////////////////////////////////////////////////////
    // configuration capture and invalidation
    logic [1:0] mode_q, mode_d;
    logic [2:0] tim_q, tim_d;
    logic       inval;
    logic       prog_s1_q, prog_s2_q, prog_s3_q;

    // reserved mode and zero timing are ignored so the previous setting stays
    always_comb begin
        mode_d = (accel_mode_control == FFA_MODE_RSVD) ? mode_q : accel_mode_control;
        tim_d  = (flash_access_timing == 3'h0) ? tim_q : flash_access_timing;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_q    <= `FFA_MODE_RST;
            tim_q     <= `FFA_TIM_RST;
            prog_s1_q <= 1'b0;
            prog_s2_q <= 1'b0;
            prog_s3_q <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            tim_q     <= tim_d;
            prog_s1_q <= prog_start;
            prog_s2_q <= prog_s1_q;
            prog_s3_q <= prog_s2_q;
        end
    end

    // flush on mode change or the rising edge of a program/erase start
    assign inval = (mode_d != mode_q) || (prog_s2_q && !prog_s3_q);

    ////////////////////////////////////////////////////////////////////////////////
    // request decode
    logic [`FFA_CMP_W-1:0]  req_line;
    logic                   req_bank;
    logic [1:0]             req_word;
    logic                   req_hw;
    // word bits stay out of the compare so all four words of a line hit; bit 1 is the bank
    assign req_line = {addr[`FFA_ADDR_W-1:`FFA_BANK_BIT], 1'h0};
    assign req_bank = addr[`FFA_BANK_BIT];
    assign req_word = addr[3:2];
    assign req_hw   = addr[1];

    ////////////////////////////////////////////////////////////////////////////////
    // per-bank buffers and flash ports
    logic [`FFA_LINE_W-1:0] pf_line_q [2], pf_line_d [2];
    logic [`FFA_CMP_W-1:0]  pf_tag_q [2], pf_tag_d [2];
    logic                   pf_ok_q [2], pf_ok_d [2];
    logic [`FFA_LINE_W-1:0] bt_line_q [2], bt_line_d [2];
    logic [`FFA_CMP_W-1:0]  bt_tag_q [2], bt_tag_d [2];
    logic                   bt_ok_q [2], bt_ok_d [2];
    logic                   pf_run_q [2], pf_run_d [2];   // 1: bank read is a prefetch
    logic                   pf_hit [2], bt_hit [2], pf_pend [2];
    logic                   bk_start [2], bk_busy [2], bk_done [2];
    logic [`FFA_CMP_W-1:0]  bk_line_addr [2], bk_addr [2];
    logic [`FFA_LINE_W-1:0] bk_line [2], bk_rd [2];
    logic [`FFA_CMP_W-1:0]  next_line;

    assign bk_rd[0] = bank0_rd_line;
    assign bk_rd[1] = bank1_rd_line;
    // the cross-bank incrementer feeds the bank 0 latch: bank 1 line n is followed by bank 0 line n+1
    assign next_line = {bk_addr[1][`FFA_CMP_W-1:2] + 10'h001, 2'h0};

    genvar gb;
    generate
        for (gb = 0; gb < 2; gb++) begin : g_bank
            ffa_bank u_bank (
                .ref_clk     (ref_clk),
                .rst         (rst),
                .start       (bk_start[gb]),
                .line_addr   (bk_line_addr[gb]),
                .access_clks (tim_q),
                .rd_line     (bk_rd[gb]),
                .bank_addr   (bk_addr[gb]),
                .busy        (bk_busy[gb]),
                .done        (bk_done[gb]),
                .line_out    (bk_line[gb])
            );
            assign pf_hit[gb]  = pf_ok_q[gb] && (pf_tag_q[gb] == req_line);
            assign bt_hit[gb]  = bt_ok_q[gb] && (bt_tag_q[gb] == req_line);
            assign pf_pend[gb] = bk_busy[gb] && pf_run_q[gb] && (bk_addr[gb] == req_line);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // data buffer
    logic [`FFA_LINE_W-1:0] dl_line_q, dl_line_d;
    logic [`FFA_DCMP_W-1:0] dl_tag_q, dl_tag_d;
    logic                   dl_ok_q, dl_ok_d;
    logic                   dl_hit;
    assign dl_hit = dl_ok_q && (dl_tag_q == {req_bank, req_line});

    ////////////////////////////////////////////////////////////////////////////////
    // wait logic and buffer control
    ffa_state_type          st_q, st_d;
    logic                   miss_bank_q, miss_bank_d;
    logic                   miss_data_q, miss_data_d;
    logic                   stall_q, stall_d;
    logic                   valid_q, valid_d;
    logic [31:0]            rdata_q, rdata_d;
    logic [`FFA_LINE_W-1:0] src;
    logic                   hit_now;
    logic                   allow_pf;
    logic                   use_latch;

    // mode off or partial non-sequential code / any non-full data must go to flash
    assign allow_pf  = (mode_q == FFA_MODE_PART) || (mode_q == FFA_MODE_FULL);
    assign use_latch = is_data ? (mode_q == FFA_MODE_FULL)
                               : ((mode_q == FFA_MODE_FULL) || ((mode_q == FFA_MODE_PART) && seq));

    // word or halfword pick out of a 128-bit line
    function automatic logic [31:0] ffa_pick(input logic [`FFA_LINE_W-1:0] ln, input logic [1:0] w,
                                             input logic h, input logic hs);
        logic [31:0] wd;
        wd = ln[32*w +: 32];
        ffa_pick = h ? {16'h0000, (hs ? wd[31:16] : wd[15:0])} : wd;
    endfunction : ffa_pick

    always_comb begin
        st_d        = st_q;
        miss_bank_d = miss_bank_q;
        miss_data_d = miss_data_q;
        stall_d     = 1'b0;
        valid_d     = 1'b0;
        rdata_d     = rdata_q;
        dl_line_d   = dl_line_q;
        dl_tag_d    = dl_tag_q;
        dl_ok_d     = dl_ok_q;
        src         = '0;
        hit_now     = 1'b0;
        for (int b = 0; b < 2; b++) begin
            pf_line_d[b]    = pf_line_q[b];
            pf_tag_d[b]     = pf_tag_q[b];
            pf_ok_d[b]      = pf_ok_q[b];
            bt_line_d[b]    = bt_line_q[b];
            bt_tag_d[b]     = bt_tag_q[b];
            bt_ok_d[b]      = bt_ok_q[b];
            pf_run_d[b]     = pf_run_q[b];
            bk_start[b]     = 1'b0;
            bk_line_addr[b] = bk_addr[b];
            // a finished speculative read lands in the prefetch buffer
            if (bk_done[b] && pf_run_q[b]) begin
                pf_line_d[b] = bk_line[b];
                pf_tag_d[b]  = bk_addr[b];
                pf_ok_d[b]   = 1'b1;
                pf_run_d[b]  = 1'b0;
            end
        end
        if (!is_data) begin
            if (bt_hit[req_bank]) begin
                src     = bt_line_q[req_bank];
                hit_now = 1'b1;
            end else if (pf_hit[req_bank]) begin
                src     = pf_line_q[req_bank];
                hit_now = 1'b1;
            end
        end else if (dl_hit) begin
            src     = dl_line_q;
            hit_now = 1'b1;
        end
        case (st_q)
            FFA_IDLE: begin
                if (req) begin
                    if (hit_now && use_latch) begin
                        valid_d = 1'b1;
                        rdata_d = ffa_pick(src, req_word, half, req_hw);
                        // last word of a line used: that bank heads for its next line
                        if (!is_data && allow_pf && (req_word == 2'h3) && !bk_busy[req_bank]) begin
                            bk_start[req_bank]     = 1'b1;
                            bk_line_addr[req_bank] = req_line + 12'h004; // next line, same bank
                            pf_run_d[req_bank]     = 1'b1;
                        end
                    end else if (!is_data && pf_pend[req_bank] && use_latch) begin
                        stall_d     = 1'b1;
                    end else if (!bk_busy[req_bank]) begin
                        bk_start[req_bank]     = 1'b1;
                        bk_line_addr[req_bank] = req_line;
                        pf_run_d[req_bank]     = 1'b0;
                        miss_bank_d            = req_bank;
                        miss_data_d            = is_data;
                        st_d                   = FFA_WAIT;
                        stall_d                = 1'b1;
                    end else begin
                        stall_d = 1'b1;
                    end
                end
            end
            FFA_WAIT: begin
                stall_d = 1'b1;
                if (bk_done[miss_bank_q]) begin
                    stall_d = 1'b0;
                    valid_d = 1'b1;
                    st_d    = FFA_IDLE;
                    rdata_d = ffa_pick(bk_line[miss_bank_q], req_word, half, req_hw);
                    if (miss_data_q) begin
                        dl_line_d = bk_line[miss_bank_q];
                        dl_tag_d  = {miss_bank_q, bk_addr[miss_bank_q]};
                        dl_ok_d   = 1'b1;
                    end else begin
                        bt_line_d[miss_bank_q] = bk_line[miss_bank_q];
                        bt_tag_d[miss_bank_q]  = bk_addr[miss_bank_q];
                        bt_ok_d[miss_bank_q]   = 1'b1;
                        // the other bank goes for the following sequential line
                        if (allow_pf && !bk_busy[~miss_bank_q]) begin
                            bk_start[~miss_bank_q]     = 1'b1;
                            bk_line_addr[~miss_bank_q] = miss_bank_q ? next_line
                                                                     : {bk_addr[0][`FFA_CMP_W-1:2], 2'h2};
                            pf_run_d[~miss_bank_q]     = 1'b1;
                        end
                    end
                end
            end
            default: st_d = FFA_IDLE;
        endcase
        // flush wins over any fill in the same cycle so no stale line survives
        if (inval) begin
            for (int b = 0; b < 2; b++) begin
                pf_ok_d[b] = 1'b0;
                pf_run_d[b] = 1'b0; // a prefetch read in flight must not land as valid after a flush
                bt_ok_d[b] = 1'b0;
            end
            dl_ok_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q        <= FFA_IDLE;
            miss_bank_q <= 1'b0;
            miss_data_q <= 1'b0;
            stall_q     <= 1'b0;
            valid_q     <= 1'b0;
            rdata_q     <= 32'h0000_0000;
            dl_line_q   <= '0;
            dl_tag_q    <= '0;
            dl_ok_q     <= 1'b0;
            for (int b = 0; b < 2; b++) begin
                pf_line_q[b] <= '0;
                pf_tag_q[b]  <= '0;
                pf_ok_q[b]   <= 1'b0;
                bt_line_q[b] <= '0;
                bt_tag_q[b]  <= '0;
                bt_ok_q[b]   <= 1'b0;
                pf_run_q[b]  <= 1'b0;
            end
        end else begin
            st_q        <= st_d;
            miss_bank_q <= miss_bank_d;
            miss_data_q <= miss_data_d;
            stall_q     <= stall_d;
            valid_q     <= valid_d;
            rdata_q     <= rdata_d;
            dl_line_q   <= dl_line_d;
            dl_tag_q    <= dl_tag_d;
            dl_ok_q     <= dl_ok_d;
            for (int b = 0; b < 2; b++) begin
                pf_line_q[b] <= pf_line_d[b];
                pf_tag_q[b]  <= pf_tag_d[b];
                pf_ok_q[b]   <= pf_ok_d[b];
                bt_line_q[b] <= bt_line_d[b];
                bt_tag_q[b]  <= bt_tag_d[b];
                bt_ok_q[b]   <= bt_ok_d[b];
                pf_run_q[b]  <= pf_run_d[b];
            end
        end
    end

    // flash programming itself happens elsewhere; only its start is seen here
    assign bank0_addr  = bk_addr[0];
    assign bank1_addr  = bk_addr[1];
    assign stall       = stall_q;
    assign rdata_valid = valid_q;
    assign rdata       = rdata_q;
endmodule : ffa_accel

// >>> ffa_accel_asserts.sv
// checker for the flash fetch accelerator: timing relations between request, stall and answer
// assumes it is bound into every ffa_accel instance and sees only its ports
`timescale 1ns/1ps
module ffa_accel_asserts
    import ffa_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [1:0]  accel_mode_control,
    input wire logic [2:0]  flash_access_timing,
    input wire logic        req,
    input wire logic        stall,
    input wire logic        rdata_valid,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // answer handshake
    property p_valid_pulse; rdata_valid |=> !rdata_valid; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("answer pulse too long");
    property p_valid_cause; rdata_valid |-> $past(req); endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("answer without request");
    property p_stall_excl; stall |-> !rdata_valid; endproperty
    a_stall_excl: assert property (p_stall_excl) else $error("answer while stalled");
    property p_stall_cause; stall |-> $past(req); endproperty
    a_stall_cause: assert property (p_stall_cause) else $error("stall without request");
    property p_rdata_hold; !rdata_valid |-> $stable(rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved between answers");
    ////////////////////////////////////////////////////////////////////////////////
    // mode and access time; a mode change is left a few cycles to take effect
    property p_off_slow;
        rdata_valid && accel_mode_control == 2'h0 && $past(accel_mode_control, 3) == 2'h0 |-> $past(stall);
    endproperty
    a_off_slow: assert property (p_off_slow) else $error("fast answer with acceleration off");
    property p_timing_floor;
        $rose(stall) && flash_access_timing == 3'h7 && $stable(flash_access_timing) |-> stall [*7];
    endproperty
    a_timing_floor: assert property (p_timing_floor) else $error("flash access shorter than set");
    property p_stall_bound; $rose(stall) |-> ##[1:30] !stall; endproperty
    a_stall_bound: assert property (p_stall_bound) else $error("stall never ends");
endmodule : ffa_accel_asserts
bind ffa_accel ffa_accel_asserts ffa_accel_asserts_i (.ref_clk(ref_clk), .rst(rst),
    .accel_mode_control(accel_mode_control), .flash_access_timing(flash_access_timing), .req(req),
    .stall(stall), .rdata_valid(rdata_valid), .rdata(rdata));

// >>> ffa_flash_model.sv
// behavioural flash bank array: answers a full line for the latched line address
// assumes one instance per bank; contents are a pattern of bank, line and word index
`timescale 1ns/1ps
module ffa_flash_model #(
    parameter logic BANK = 1'b0
) (
    input  wire logic [11:0]  bank_addr,
    output logic      [127:0] rd_line
);
    // each bank reads on its own, so two instances work in parallel
    always_comb begin
        for (int w = 0; w < 4; w++) begin
            rd_line[w*32 +: 32] = {3'h0, BANK, 2'h0, bank_addr[11:2], 2'(w), 6'h0, 8'ha5};
        end
    end
endmodule : ffa_flash_model

// >>> ffa_accel_test.sv
// self-checking bench for the flash fetch accelerator
// assumes ffa_flash_model drives both bank lines and the checker is bound in
`timescale 1ns/1ps
module ffa_accel_test;
    import ffa_pkg::*;
    logic         ref_clk, rst, prog_start, req, is_data, seq, half, stall, rdata_valid;
    logic [1:0]   accel_mode_control;
    logic [2:0]   flash_access_timing;
    logic [14:0]  addr;
    logic [127:0] bank0_rd_line, bank1_rd_line;
    logic [11:0]  bank0_addr, bank1_addr;
    logic [31:0]  rdata;
    int           error_cnt, compares, lat, lm, prev, seed;
    // free running 40 mhz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    ffa_accel ffa_accel_i (.ref_clk(ref_clk), .rst(rst), .accel_mode_control(accel_mode_control),
        .flash_access_timing(flash_access_timing), .prog_start(prog_start), .req(req), .is_data(is_data),
        .seq(seq), .half(half), .addr(addr), .bank0_rd_line(bank0_rd_line), .bank1_rd_line(bank1_rd_line),
        .bank0_addr(bank0_addr), .bank1_addr(bank1_addr), .stall(stall), .rdata_valid(rdata_valid),
        .rdata(rdata));
    ffa_flash_model #(.BANK(1'b0)) flash0_i (.bank_addr(bank0_addr), .rd_line(bank0_rd_line));
    ffa_flash_model #(.BANK(1'b1)) flash1_i (.bank_addr(bank1_addr), .rd_line(bank1_rd_line));
    ////////////////////////////////////////////////////////////////////////////////
    // reference word: same pattern as the bank model, picked by word and halfword bits
    function automatic logic [31:0] exp_word(input int a, input int h);
        int w;
        w = (((a >> 4) & 1) << 28) | (((a >> 5) & 'h3ff) << 16) | (((a >> 2) & 3) << 14) | 'ha5;
        if (h != 0) return ((a >> 1) & 1) ? 32'(w >>> 16) & 32'hffff : 32'(w) & 32'hffff;
        return 32'(w);
    endfunction : exp_word
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    // one core request held until the answer pulse; lat counts cycles to it
    task automatic access(input logic [14:0] a, input logic d, input logic h, input logic s, output int n);
        @(negedge ref_clk);
        addr = a; is_data = d; half = h; seq = s; req = 1'b1; n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (rdata_valid !== 1'b1 && n < 40);
        req = 1'b0;
        if (n >= 40) begin
            error_cnt++;
            $display("BAD answer timeout expected %h seen %h", 1, 0);
            stop_test();
        end else check("rdata", exp_word(int'(a), int'(h)), rdata);
    endtask : access
    // configuration changes only while idle, then let them settle
    task automatic set_cfg(input logic [1:0] m, input logic [2:0] t);
        @(negedge ref_clk);
        accel_mode_control = m; flash_access_timing = t;
        repeat (4) @(negedge ref_clk);
    endtask : set_cfg
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        seed = 85924; error_cnt = 0; compares = 0; prev = 0;
        rst = 1'b1; prog_start = 1'b0; req = 1'b0; is_data = 1'b0; seq = 1'b0; half = 1'b0;
        addr = 15'h0000; accel_mode_control = 2'h0; flash_access_timing = 3'h7;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        check("stall", 32'h0, 32'(stall));
        check("rdata", 32'h0, rdata);
        // off mode: every access is a full flash read, one cycle longer per timing step
        for (int t = 1; t < 8; t++) begin
            set_cfg(2'h0, 3'(t));
            access(15'h0120, 1'b0, 1'b0, 1'b0, lat);
            access(15'h0120, 1'b0, 1'b0, 1'b1, lm);
            check("off_repeat", 32'(lat), 32'(lm));
            if (t > 1) check("timing_step", 32'(prev + 1), 32'(lat));
            prev = lat;
        end
        $display("test timing done");
        // full mode: miss, hits in line, prefetched next line, branch back, far miss
        set_cfg(2'h2, 3'h4);
        access(15'h0200, 1'b0, 1'b0, 1'b0, lm);
        check("miss_slow", 32'h1, 32'(lm > 2));
        check("bank0_addr", 32'((15'h0200 >> 4) << 1), 32'(bank0_addr));
        check("bank1_addr", 32'((15'h0210 >> 4) << 1), 32'(bank1_addr));
        access(15'h0204, 1'b0, 1'b0, 1'b1, lat);
        check("line_hit", 32'h1, 32'(lat <= 2));
        access(15'h0206, 1'b0, 1'b1, 1'b1, lat);
        check("half_hit", 32'h1, 32'(lat <= 2));
        access(15'h020c, 1'b0, 1'b0, 1'b1, lat);
        access(15'h0210, 1'b0, 1'b0, 1'b1, lat);
        check("prefetch_used", 32'h1, 32'(lat < lm));
        access(15'h0200, 1'b0, 1'b0, 1'b0, lat);
        check("trail_hit", 32'h1, 32'(lat <= 2));
        access(15'h4000, 1'b0, 1'b0, 1'b0, lat);
        check("far_miss", 32'h1, 32'(lat > 2));
        access(15'h4004, 1'b0, 1'b0, 1'b1, lat);
        check("after_miss", 32'h1, 32'(lat <= 2));
        $display("test instruction done");
        // data reads: own line buffer, no prefetch
        access(15'h1300, 1'b1, 1'b0, 1'b0, lat);
        check("data_miss", 32'h1, 32'(lat > 2));
        access(15'h130c, 1'b1, 1'b0, 1'b0, lat);
        check("data_hit", 32'h1, 32'(lat <= 2));
        access(15'h1310, 1'b1, 1'b0, 1'b0, lat);
        check("data_no_prefetch", 32'h1, 32'(lat > 2));
        access(15'h1300, 1'b0, 1'b0, 1'b0, lat);
        check("code_apart", 32'h1, 32'(lat > 2));
        $display("test data done");
        // mode change and partial mode
        access(15'h0500, 1'b0, 1'b0, 1'b0, lat);
        set_cfg(2'h1, 3'h4);
        access(15'h0504, 1'b0, 1'b0, 1'b1, lat);
        check("mode_flush", 32'h1, 32'(lat > 2));
        access(15'h0508, 1'b0, 1'b0, 1'b1, lat);
        check("part_seq", 32'h1, 32'(lat <= 2));
        access(15'h0504, 1'b0, 1'b0, 1'b0, lat);
        check("part_branch", 32'h1, 32'(lat > 2));
        access(15'h0700, 1'b1, 1'b0, 1'b0, lat);
        access(15'h0704, 1'b1, 1'b0, 1'b0, lat);
        check("part_data", 32'h1, 32'(lat > 2));
        set_cfg(2'h2, 3'h4);
        $display("test mode done");
        // programming start flushes code and data lines
        access(15'h0800, 1'b0, 1'b0, 1'b0, lat);
        access(15'h0900, 1'b1, 1'b0, 1'b0, lat);
        @(negedge ref_clk);
        prog_start = 1'b1;
        repeat (4) @(negedge ref_clk);
        prog_start = 1'b0;
        repeat (3) @(negedge ref_clk);
        access(15'h0804, 1'b0, 1'b0, 1'b1, lat);
        check("prog_code", 32'h1, 32'(lat > 2));
        access(15'h0904, 1'b1, 1'b0, 1'b0, lat);
        check("prog_data", 32'h1, 32'(lat > 2));
        $display("test program flush done");
        // random traffic in all modes and timings
        for (int i = 0; i < 300; i++) begin
            if (i % 25 == 0) set_cfg(2'($random(seed)), 3'($random(seed) % 7 + 1));
            half = 1'($random(seed));
            access(15'($random(seed)) & (half ? 15'h7ffe : 15'h7ffc), 1'($random(seed)), half,
                   1'($random(seed)), lat);
        end
        $display("test random done");
        stop_test();
    end
endmodule : ffa_accel_test
